// ==== core/gpltc_pkg.sv ====
// constants shared by the link and transmit-mode control block
// assumes one symbol clock at 100 MHz and a synchronous reset
`default_nettype none

package gpltc_pkg;

    // ==========================================================
    // link control, link status and transmit mode codes
    localparam logic [1:0] LC_SCAN    = 2'h0;
    localparam logic [1:0] LC_DISABLE = 2'h1;
    localparam logic [1:0] LC_ENABLE  = 2'h2;
    localparam logic [1:0] LS_FAIL    = 2'h0;
    localparam logic [1:0] LS_READY   = 2'h1;
    localparam logic [1:0] LS_OK      = 2'h2;
    localparam logic [1:0] TXM_SEND_N = 2'h0;
    localparam logic [1:0] TXM_SEND_I = 2'h1;
    localparam logic [1:0] TXM_SEND_Z = 2'h2;

    // ==========================================================
    // quinary symbols, two's complement
    localparam logic [2:0] SYM_P2 = 3'h2;
    localparam logic [2:0] SYM_ZERO = 3'h0;
    localparam logic [2:0] SYM_M2 = 3'h6;
    localparam logic [2:0] SYM_OFS = 3'h2;

    // ==========================================================
    // register map
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_RXCFG  = 4'h8;
    localparam int CTRL_LPI_EN  = 0;
    localparam int CTRL_TRAIN   = 1;
    localparam int CTRL_ZERO    = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int RXCFG_POL_LSB = 0;
    localparam int RXCFG_SWAB    = 4;
    localparam int RXCFG_SWCD    = 5;
    localparam int RXCFG_DLY_LSB = 6;
    localparam logic [13:0] RXCFG_RESET = 14'h0000;
    localparam int ST_LS_LSB   = 0;
    localparam int ST_TXM_LSB  = 2;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_REMOK    = 9;
    localparam int ST_REMLPI   = 10;

    // ==========================================================
    // low power idle timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int LPI_IDLE_NS   = 2000;
    localparam int LPI_QUIET_NS  = 20000;
    localparam int LPI_IDLE_CYC =
        (LPI_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LPI_QUIET_CYC =
        (LPI_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] LFSR_SEED = 11'h5A5;

    // ==========================================================
    // state machines
    typedef enum logic [4:0] {
        CS_OFF       = 5'h01,
        CS_TRAIN     = 5'h02,
        CS_NORMAL    = 5'h04,
        CS_LPI_IDLE  = 5'h08,
        CS_LPI_QUIET = 5'h10
    } gpltc_ctl_type;

    typedef enum logic [2:0] {
        LM_FAIL  = 3'h1,
        LM_READY = 3'h2,
        LM_OK    = 3'h4
    } gpltc_lm_type;

endpackage

`default_nettype wire

// ==== core/gpltc_linkmon.sv ====
// link monitor: derives link status from link control and receiver
// assumes link control comes from logic on the same clock
`timescale 1ns/1ns
`default_nettype none

module gpltc_linkmon
    import gpltc_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // inputs
    input  wire logic [1:0] linkControl,
    input  wire logic       signalDetect,
    input  wire logic       locRcvrOk,
    // status
    output logic      [1:0] linkStatus
);

    gpltc_lm_type lmState_reg;

    // ==========================================================
    // monitor state and reported status
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            lmState_reg <= LM_FAIL;
            linkStatus  <= LS_FAIL;
        end
        else if (linkControl != LC_ENABLE)
        begin
            lmState_reg <= LM_FAIL;
            linkStatus  <= LS_FAIL;
        end
        else
        begin
            case (lmState_reg)
            LM_FAIL:
                if (signalDetect)
                begin
                    lmState_reg <= LM_READY;
                    linkStatus  <= LS_READY;
                end
            LM_READY:
                if (!signalDetect)
                begin
                    lmState_reg <= LM_FAIL;
                    linkStatus  <= LS_FAIL;
                end
                else if (locRcvrOk)
                begin
                    lmState_reg <= LM_OK;
                    linkStatus  <= LS_OK;
                end
            LM_OK:
                if (!signalDetect)
                begin
                    lmState_reg <= LM_FAIL;
                    linkStatus  <= LS_FAIL;
                end
                else if (!locRcvrOk)
                begin
                    lmState_reg <= LM_READY;
                    linkStatus  <= LS_READY;
                end
            default:
            begin
                lmState_reg <= LM_FAIL;
                linkStatus  <= LS_FAIL;
            end
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== core/gpltc_rxlane.sv ====
// one receive pair: deskew delay, polarity fix and level clamp
// assumes symbols arrive once per clock in two's complement
`timescale 1ns/1ns
`default_nettype none

module gpltc_rxlane
    import gpltc_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // lane control
    input  wire logic       invert,
    input  wire logic [1:0] delay,
    // symbols
    input  wire logic [2:0] symIn,
    output logic      [2:0] symOut
);

    logic [2:0] hist_reg [3];
    logic [2:0] picked;
    logic [2:0] fixed;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            hist_reg[0] <= SYM_ZERO;
            hist_reg[1] <= SYM_ZERO;
            hist_reg[2] <= SYM_ZERO;
        end
        else
        begin
            hist_reg[0] <= symIn;
            hist_reg[1] <= hist_reg[0];
            hist_reg[2] <= hist_reg[1];
        end
    end

    // out-of-range codes forced to nearest level
    always_comb
    begin
        picked = (delay == 2'h0) ? symIn : hist_reg[delay - 2'h1];
        fixed  = invert ? 3'(SYM_ZERO - picked) : picked;
        if (fixed == 3'h3)
            fixed = SYM_P2;
        else if (fixed == 3'h4 || fixed == 3'h5)
            fixed = SYM_M2;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            symOut <= SYM_ZERO;
        else
            symOut <= fixed;
    end

endmodule

`default_nettype wire

// ==== core/gpltc_core.sv ====
// link control, link status and transmit mode for a four-pair PHY
// assumes negotiation logic and encoder users share core_clk
`timescale 1ns/1ns
`default_nettype none

module gpltc_core
    import gpltc_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // negotiation side
    input  wire logic [1:0]  linkControl,
    output logic      [1:0]  linkStatus,
    // receiver condition
    input  wire logic        signalDetect,
    input  wire logic        locRcvrOk,
    // media independent side
    input  wire logic        txEn,
    input  wire logic [7:0]  txd,
    input  wire logic        lpiAssert,
    output logic      [7:0]  rxd,
    output logic             remLpiSeen,
    output logic             remRcvrOk,
    // transmit control
    output logic      [1:0]  txMode,
    output logic             lpiMode,
    // symbols per pair
    output logic      [2:0]  txSymA,
    output logic      [2:0]  txSymB,
    output logic      [2:0]  txSymC,
    output logic      [2:0]  txSymD,
    input  wire logic [2:0]  rxSymA,
    input  wire logic [2:0]  rxSymB,
    input  wire logic [2:0]  rxSymC,
    input  wire logic [2:0]  rxSymD,
    // register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData
);

    gpltc_ctl_type ctlState_reg;
    logic [15:0]   timer_reg;
    logic [2:0]    ctrl_reg;
    logic [13:0]   rxCfg_reg;
    logic [10:0]   lfsr_reg;
    logic [2:0]    rawSym [4];
    logic [2:0]    corrSym [4];
    logic [11:0]   idleSyms;
    logic [11:0]   dataSyms;
    logic [31:0]   statusWord;
    logic          lpiEn;
    logic          forceTrain;
    logic          zeroInLpi;
    logic          rcvrsOk;
    logic          lpiSignal;
    logic          remIdleSeen;

    assign lpiEn      = ctrl_reg[CTRL_LPI_EN];
    assign forceTrain = ctrl_reg[CTRL_TRAIN];
    assign zeroInLpi  = ctrl_reg[CTRL_ZERO];
    assign rcvrsOk    = locRcvrOk && remRcvrOk;
    assign lpiSignal  = lpiEn && lpiAssert;

    // ==========================================================
    // symbol mapping helpers
    function automatic logic [2:0] idleLevel(input logic b);
        return b ? SYM_P2 : SYM_M2;
    endfunction

    function automatic logic [11:0] octetToSyms(input logic [7:0] v);
        logic [7:0]  q;
        logic [7:0]  t;
        logic [11:0] s;
        q = v;
        s = 12'h000;
        for (int i = 0; i < 4; i++)
        begin
            t = q % 8'h05;
            s[i*3 +: 3] = 3'(t[2:0] - SYM_OFS);
            q = q / 8'h05;
        end
        return s;
    endfunction

    function automatic logic [7:0] symsToOctet(input logic [11:0] s);
        logic [9:0] acc;
        logic [2:0] d;
        acc = 10'h000;
        for (int i = 3; i >= 0; i--)
        begin
            d = 3'(s[i*3 +: 3] + SYM_OFS);
            acc = 10'(acc * 10'h005) + {7'h00, d};
        end
        return acc[7:0];
    endfunction

    // ==========================================================
    // link monitor
    gpltc_linkmon linkMon
    (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .linkControl  (linkControl),
        .signalDetect (signalDetect),
        .locRcvrOk    (locRcvrOk),
        .linkStatus   (linkStatus)
    );

    // ==========================================================
    // receive pair correction
    always_comb
    begin
        rawSym[0] = rxCfg_reg[RXCFG_SWAB] ? rxSymB : rxSymA;
        rawSym[1] = rxCfg_reg[RXCFG_SWAB] ? rxSymA : rxSymB;
        rawSym[2] = rxCfg_reg[RXCFG_SWCD] ? rxSymD : rxSymC;
        rawSym[3] = rxCfg_reg[RXCFG_SWCD] ? rxSymC : rxSymD;
    end

    generate
        for (genvar p = 0; p < 4; p++)
        begin : gLane
            gpltc_rxlane lane
            (
                .core_clk (core_clk),
                .resetn   (resetn),
                .invert   (rxCfg_reg[RXCFG_POL_LSB + p]),
                .delay    (rxCfg_reg[RXCFG_DLY_LSB + 2*p +: 2]),
                .symIn    (rawSym[p]),
                .symOut   (corrSym[p])
            );
        end
    endgenerate

    // idle groups have even levels and live pairs A and B
    assign remIdleSeen = !corrSym[0][0] && !corrSym[1][0]
        && !corrSym[2][0] && !corrSym[3][0]
        && corrSym[0] != SYM_ZERO && corrSym[1] != SYM_ZERO;

    // ==========================================================
    // receive decode and remote indications
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            rxd <= 8'h00;
        else if (linkControl != LC_ENABLE)
            rxd <= 8'h00;
        else
            rxd <= symsToOctet({corrSym[3], corrSym[2],
                                corrSym[1], corrSym[0]});
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            remRcvrOk  <= 1'b0;
            remLpiSeen <= 1'b0;
        end
        else if (linkControl != LC_ENABLE)
        begin
            remRcvrOk  <= 1'b0;
            remLpiSeen <= 1'b0;
        end
        else if (remIdleSeen)
        begin
            remRcvrOk  <= corrSym[3] != SYM_ZERO;
            remLpiSeen <= corrSym[2] == SYM_ZERO;
        end
    end

    // ==========================================================
    // phy control state machine
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ctlState_reg <= CS_OFF;
            timer_reg    <= 16'h0000;
        end
        else if (linkControl != LC_ENABLE)
        begin
            ctlState_reg <= CS_OFF;
            timer_reg    <= 16'h0000;
        end
        else if (linkStatus == LS_FAIL)
            ctlState_reg <= CS_OFF;
        else
        begin
            case (ctlState_reg)
            CS_OFF:
                ctlState_reg <= CS_TRAIN;
            CS_TRAIN:
                if (rcvrsOk && !forceTrain)
                    ctlState_reg <= CS_NORMAL;
            CS_NORMAL:
                if (!rcvrsOk || forceTrain)
                    ctlState_reg <= CS_TRAIN;
                else if (lpiSignal && remLpiSeen)
                begin
                    ctlState_reg <= CS_LPI_IDLE;
                    timer_reg    <= 16'(LPI_IDLE_CYC - 1);
                end
            CS_LPI_IDLE:
                if (!lpiSignal)
                    ctlState_reg <= CS_NORMAL;
                else if (timer_reg != 16'h0000)
                    timer_reg <= timer_reg - 16'h0001;
                else if (zeroInLpi)
                begin
                    ctlState_reg <= CS_LPI_QUIET;
                    timer_reg    <= 16'(LPI_QUIET_CYC - 1);
                end
            CS_LPI_QUIET:
                if (!lpiSignal)
                    ctlState_reg <= CS_NORMAL;
                else if (timer_reg != 16'h0000)
                    timer_reg <= timer_reg - 16'h0001;
                else
                begin
                    ctlState_reg <= CS_LPI_IDLE;
                    timer_reg    <= 16'(LPI_IDLE_CYC - 1);
                end
            default:
                ctlState_reg <= CS_OFF;
            endcase
        end
    end

    // ==========================================================
    // transmit mode, registered once per symbol
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            txMode  <= TXM_SEND_Z;
            lpiMode <= 1'b0;
        end
        else
        begin
            lpiMode <= ctlState_reg == CS_LPI_IDLE
                || ctlState_reg == CS_LPI_QUIET;
            case (ctlState_reg)
            CS_NORMAL:    txMode <= TXM_SEND_N;
            CS_TRAIN:     txMode <= TXM_SEND_I;
            CS_LPI_IDLE:  txMode <= TXM_SEND_I;
            default:      txMode <= TXM_SEND_Z;
            endcase
        end
    end

    // ==========================================================
    // idle pattern source
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            lfsr_reg <= LFSR_SEED;
        else
            lfsr_reg <= {lfsr_reg[9:0], lfsr_reg[10] ^ lfsr_reg[8]};
    end

    // pair C zero asks for low power idle, pair D zero for retrain
    always_comb
    begin
        idleSyms[2:0]  = idleLevel(lfsr_reg[0]);
        idleSyms[5:3]  = idleLevel(lfsr_reg[3]);
        idleSyms[8:6]  = lpiSignal ? SYM_ZERO
                                   : idleLevel(lfsr_reg[6]);
        idleSyms[11:9] = locRcvrOk ? idleLevel(lfsr_reg[9])
                                   : SYM_ZERO;
        dataSyms       = octetToSyms(txd);
    end

    // ==========================================================
    // transmit symbols
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            txSymA <= SYM_ZERO;
            txSymB <= SYM_ZERO;
            txSymC <= SYM_ZERO;
            txSymD <= SYM_ZERO;
        end
        else
        begin
            case (txMode)
            TXM_SEND_N:
                {txSymD, txSymC, txSymB, txSymA} <=
                    txEn ? dataSyms : idleSyms;
            TXM_SEND_I:
                {txSymD, txSymC, txSymB, txSymA} <= idleSyms;
            default:
                {txSymD, txSymC, txSymB, txSymA} <= 12'h000;
            endcase
        end
    end

    // ==========================================================
    // register writes
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ctrl_reg  <= CTRL_RESET;
            rxCfg_reg <= RXCFG_RESET;
        end
        else if (regWr)
        begin
            if (regAddr == ADDR_CTRL)
                ctrl_reg <= regWrData[2:0];
            else if (regAddr == ADDR_RXCFG)
                rxCfg_reg <= regWrData[13:0];
        end
    end

    // ==========================================================
    // register reads
    always_comb
    begin
        statusWord = 32'h0000_0000;
        statusWord[ST_LS_LSB +: 2]   = linkStatus;
        statusWord[ST_TXM_LSB +: 2]  = txMode;
        statusWord[ST_MODE_LSB +: 5] = ctlState_reg;
        statusWord[ST_REMOK]         = remRcvrOk;
        statusWord[ST_REMLPI]        = remLpiSeen;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            regRdData <= 32'h0000_0000;
        else if (!regRd)
            regRdData <= 32'h0000_0000;
        else if (regAddr == ADDR_CTRL)
            regRdData <= {29'h0000_0000, ctrl_reg};
        else if (regAddr == ADDR_STATUS)
            regRdData <= statusWord;
        else if (regAddr == ADDR_RXCFG)
            regRdData <= {18'h0_0000, rxCfg_reg};
        else
            regRdData <= 32'h0000_0000;
    end

endmodule

`default_nettype wire

// ==== verification/gpltc_checker.sv ====
// checker: link status and transmit mode timing at the core ports
// assumes a bind onto gpltc_core, one clock domain
`timescale 1ns/1ns
`default_nettype none

module gpltc_checker
    import gpltc_pkg::*;
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // observed ports
    input wire logic [1:0] linkControl,
    input wire logic [1:0] linkStatus,
    input wire logic       signalDetect,
    input wire logic       locRcvrOk,
    input wire logic [1:0] txMode,
    input wire logic [2:0] txSymA,
    input wire logic [2:0] txSymB,
    input wire logic [2:0] txSymC,
    input wire logic [2:0] txSymD
);
    logic [11:0] syms;
    logic        idleOk;
    logic        lvlOk;

    assign syms = {txSymA, txSymB, txSymC, txSymD};
    assign idleOk = txSymA inside {SYM_P2, SYM_ZERO, SYM_M2}
        && txSymB inside {SYM_P2, SYM_ZERO, SYM_M2}
        && txSymC inside {SYM_P2, SYM_ZERO, SYM_M2}
        && txSymD inside {SYM_P2, SYM_ZERO, SYM_M2};
    assign lvlOk = !(txSymA inside {3'h3, 3'h4, 3'h5})
        && !(txSymB inside {3'h3, 3'h4, 3'h5})
        && !(txSymC inside {3'h3, 3'h4, 3'h5})
        && !(txSymD inside {3'h3, 3'h4, 3'h5});

    // ==========================================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_off;
        (linkControl != LC_ENABLE) [*2];
    endsequence

    property p_mode_legal;
        txMode != 2'h3;
    endproperty
    property p_not_en_fail;
        linkControl != LC_ENABLE |=> linkStatus == LS_FAIL;
    endproperty
    property p_off_sendz;
        s_off |=> txMode == TXM_SEND_Z;
    endproperty
    property p_z_syms;
        txMode == TXM_SEND_Z |=> syms == 12'h000;
    endproperty
    property p_idle_set;
        txMode == TXM_SEND_I |=> idleOk;
    endproperty
    property p_five_lvl;
        lvlOk;
    endproperty
    property p_ok_rcvr;
        !locRcvrOk |=> linkStatus != LS_OK;
    endproperty
    property p_no_sig;
        !signalDetect |=> linkStatus == LS_FAIL;
    endproperty

    a_mode_legal: assert property (p_mode_legal)
        else $error("tx mode holds an illegal code");
    a_not_en_fail: assert property (p_not_en_fail)
        else $error("status not fail while processes disabled");
    a_off_sendz: assert property (p_off_sendz)
        else $error("disabled link not sending zeros");
    a_z_syms: assert property (p_z_syms)
        else $error("nonzero symbol in zero mode");
    a_idle_set: assert property (p_idle_set)
        else $error("idle symbol outside 2 0 -2");
    a_five_lvl: assert property (p_five_lvl)
        else $error("symbol outside five levels");
    a_ok_rcvr: assert property (p_ok_rcvr)
        else $error("status ok with unreliable receiver");
    a_no_sig: assert property (p_no_sig)
        else $error("status not fail without signal");
endmodule

bind gpltc_core gpltc_checker i_gpltc_checker (.core_clk, .resetn,
    .linkControl, .linkStatus, .signalDetect, .locRcvrOk, .txMode,
    .txSymA, .txSymB, .txSymC, .txSymD);

`default_nettype wire

// ==== verification/gpltc_partner.sv ====
// partner: negotiation logic and a remote idle symbol source
// assumes the core clock and reset
`timescale 1ns/1ns
`default_nettype none

module gpltc_partner
    import gpltc_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // scenario controls
    input  wire logic       pulsesSeen,
    input  wire logic       resolved,
    input  wire logic       remOk,
    input  wire logic       remLpi,
    // toward the core
    output logic      [1:0] linkControl,
    output logic      [2:0] rxSymA,
    output logic      [2:0] rxSymB,
    output logic      [2:0] rxSymC,
    output logic      [2:0] rxSymD
);
    logic toggle_reg;

    // ==========================================================
    // decision refreshed on every rising edge
    always_ff @(posedge core_clk)
    begin
        linkControl <= !resetn || !pulsesSeen ? LC_SCAN
            : resolved ? LC_ENABLE : LC_DISABLE;
    end

    // ==========================================================
    // remote idle: pair c zero asks lpi, pair d zero says not ok
    always_ff @(posedge core_clk)
    begin
        toggle_reg <= resetn ? !toggle_reg : 1'b0;
        rxSymA <= toggle_reg ? SYM_P2 : SYM_M2;
        rxSymB <= toggle_reg ? SYM_M2 : SYM_P2;
        rxSymC <= remLpi ? SYM_ZERO : rxSymB;
        rxSymD <= remOk ? rxSymA : SYM_ZERO;
    end
endmodule

`default_nettype wire

// ==== verification/gpltc_core_tb.sv ====
// testbench: link control, status and transmit mode of gpltc_core
// assumes the partner model and the bound checker
`timescale 1ns/1ns
`default_nettype none

module gpltc_core_tb
    import gpltc_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        signalDetect = 1'b0;
    logic        locRcvrOk = 1'b0;
    logic        txEn = 1'b0;
    logic [7:0]  txd = 8'h00;
    logic        lpiAssert = 1'b0;
    logic        pulsesSeen = 1'b0;
    logic        resolved = 1'b0;
    logic        remOk = 1'b1;
    logic        remLpi = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [1:0]  linkControl, linkStatus, txMode;
    logic [7:0]  rxd;
    logic        remLpiSeen, remRcvrOk, lpiMode;
    logic [2:0]  txSymA, txSymB, txSymC, txSymD;
    logic [2:0]  rxSymA, rxSymB, rxSymC, rxSymD;
    logic [31:0] regRdData, rdVal;
    int          mismatches = 0;
    int          compares = 0;
    int          seed = 67123;

    gpltc_core i_gpltc_core (.core_clk, .resetn, .linkControl,
        .linkStatus, .signalDetect, .locRcvrOk, .txEn, .txd, .lpiAssert,
        .rxd, .remLpiSeen, .remRcvrOk, .txMode, .lpiMode, .txSymA, .txSymB,
        .txSymC, .txSymD, .rxSymA, .rxSymB, .rxSymC, .rxSymD, .regAddr,
        .regWrData, .regWr, .regRd, .regRdData);
    gpltc_partner i_gpltc_partner (.core_clk, .resetn, .pulsesSeen,
        .resolved, .remOk, .remLpi, .linkControl, .rxSymA, .rxSymB,
        .rxSymC, .rxSymD);

    always #5 core_clk = ~core_clk;

    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_mode(input logic [1:0] m);
        int n;
        n = 0;
        while (txMode !== m && n < 3000)
        begin
            tick(1);
            n++;
        end
        check(txMode, m);
    endtask

    function automatic logic [11:0] enc(input logic [7:0] v);
        for (int k = 0; k < 4; k++)
        begin
            enc[11-3*k -: 3] = 3'(v % 5) - 3'h2;
            v = v / 5;
        end
    endfunction

    function automatic logic [31:0] stat(input logic [1:0] ls,
        input logic [1:0] tm, input logic [4:0] st, input logic rok);
        return {22'h0, rok, st, tm, ls};
    endfunction

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        mismatches++;
        report_and_stop();
    end

    // ==========================================================
    // scenarios
    initial
    begin
        logic [7:0] v;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        tick(1);
        check(linkStatus, LS_FAIL);
        wr(ADDR_STATUS, 32'hFFFFFFFF);
        rd(ADDR_STATUS);
        check(rdVal, stat(LS_FAIL, TXM_SEND_Z, 5'h01, 1'b0));
        wr(4'hC, 32'hFFFFFFFF);
        rd(4'hC);
        check(rdVal, 32'h0);
        wr(ADDR_RXCFG, 32'hFFFFFFFF);
        rd(ADDR_RXCFG);
        check(rdVal, 32'h3FFF);
        wr(ADDR_RXCFG, 32'h0);
        $display("done: reset and registers");
        tick(6);
        check({linkControl, linkStatus, txMode}, {LC_SCAN, LS_FAIL,
            TXM_SEND_Z});
        pulsesSeen <= 1'b1;
        signalDetect <= 1'b1;
        tick(6);
        check({linkControl, linkStatus, txMode, rxd}, {LC_DISABLE,
            LS_FAIL, TXM_SEND_Z, 8'h00});
        $display("done: scan and disable");
        @(posedge core_clk);
        locRcvrOk <= 1'b1;
        resolved <= 1'b1;
        wait_mode(TXM_SEND_N);
        check(linkStatus, LS_OK);
        rd(ADDR_STATUS);
        check(rdVal, stat(LS_OK, TXM_SEND_N, 5'h04, 1'b1));
        wr(ADDR_RXCFG, 32'h1 << RXCFG_SWCD);
        remOk <= 1'b0;
        tick(4);
        rd(ADDR_STATUS);
        check({rdVal[ST_REMLPI], rdVal[ST_REMOK]}, 2'h3);
        remOk <= 1'b1;
        wr(ADDR_RXCFG, 32'h0);
        $display("done: enable");
        for (int i = 0; i < 24; i++)
        begin
            v = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed));
            @(posedge core_clk);
            txEn <= 1'b1;
            txd <= v;
            tick(1);
            check({txSymA, txSymB, txSymC, txSymD}, enc(v));
        end
        wr(ADDR_CTRL, 32'h1 << CTRL_TRAIN);
        wait_mode(TXM_SEND_I);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge core_clk);
            txd <= 8'($random(seed));
            #1;
            check(txSymA == SYM_P2 || txSymA == SYM_M2, 1'b1);
        end
        txEn <= 1'b0;
        wr(ADDR_CTRL, 32'h0);
        wait_mode(TXM_SEND_N);
        $display("done: data and training");
        wr(ADDR_CTRL, 32'h5);
        rd(ADDR_CTRL);
        check(rdVal, 32'h5);
        @(posedge core_clk);
        lpiAssert <= 1'b1;
        remLpi <= 1'b1;
        wait_mode(TXM_SEND_I);
        check({lpiMode, remLpiSeen, txSymC}, {2'h3, SYM_ZERO});
        wait_mode(TXM_SEND_Z);
        @(posedge core_clk);
        lpiAssert <= 1'b0;
        remLpi <= 1'b0;
        wait_mode(TXM_SEND_N);
        check(lpiMode, 1'b0);
        $display("done: low power idle");
        @(posedge core_clk);
        locRcvrOk <= 1'b0;
        tick(2);
        check(linkStatus, LS_READY);
        wait_mode(TXM_SEND_I);
        signalDetect <= 1'b0;
        tick(2);
        check(linkStatus, LS_FAIL);
        pulsesSeen <= 1'b0;
        wait_mode(TXM_SEND_Z);
        tick(1);
        check({linkControl, rxd}, {LC_SCAN, 8'h00});
        @(posedge core_clk);
        resetn <= 1'b0;
        @(posedge core_clk);
        resetn <= 1'b1;
        rd(ADDR_CTRL);
        check(rdVal, 32'h0);
        $display("done: link loss and reset");
        report_and_stop();
    end
endmodule

`default_nettype wire
